// file: hdl/float_status_and_path_decode.sv
// Float status register, multi-way branch groups, path output decode and seed table glue
`timescale 1ns/100ps
`include "fsd_defines.svh"
module float_status_and_path_decode (
  // Clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // AHB-Lite slave
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic                    hready,
  input  wire logic [31:0]             hwdata,
  output      logic [31:0]             hrdata,
  output      logic                    hreadyout,
  output      logic                    hresp,
  // Control pipeline fields
  input  wire logic                    run,
  input  wire logic                    exec,
  input  wire fsd_pkg::dsp_t           dsp,
  input  wire logic                    f_clocked,
  input  wire logic                    seed_sel,
  input  wire logic [`BR_ADDR_W-1:0]   branch_addr,
  // Float unit status
  input  wire fsd_pkg::flags_t         fpu_flags,
  output      logic                    fpu_flag_passthru,
  output      logic                    fpu_result_passthru,
  // Output enables and holds
  output      logic                    fpu_drive_en_n,
  output      logic                    alu_drive_en_n,
  output      logic                    alu_hold,
  output      logic                    mult_drive_en_n,
  output      logic                    mult_instr_load_n,
  output      logic                    mult_instr_passthru,
  output      logic                    mult_prod_passthru,
  // Branch groups and interrupt
  output      logic [`BR_ADDR_W-1:0]   mw_target1,
  output      logic [`BR_ADDR_W-1:0]   mw_target2,
  output      logic [`BR_GRP_W-1:0]    grp1,
  output      logic [`BR_GRP_W-1:0]    grp2,
  output      logic                    fpu_err_irq,
  // Operand A bus
  input  wire logic [31:0]             a_bus_in,
  output      logic [31:0]             a_bus_out,
  output      logic                    a_bus_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Float unit counts as the path in use for both its own code and the trick
  function automatic logic float_path(input fsd_pkg::dsp_t d);
    float_path = (d == `DSP_FPU) || (d == `DSP_TRICK);
  endfunction

  function automatic logic [`BR_ADDR_W-1:0] mw_dest(input logic [`BR_ADDR_W-1:0] base,
                                                     input logic [`BR_GRP_W-1:0] g);
    mw_dest = {base[`BR_ADDR_W-1:`BR_GRP_W], g};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Path decode

  logic seed_en_r;
  logic stat_clr;

  always_comb begin
    fpu_drive_en_n  = 1'b1;
    alu_drive_en_n  = 1'b1;
    mult_drive_en_n = 1'b1;
    case (dsp)
      `DSP_ALU:   alu_drive_en_n  = 1'b0;
      `DSP_FPU:   fpu_drive_en_n  = 1'b0;
      `DSP_MULT:  mult_drive_en_n = 1'b0;
      `DSP_TRICK: alu_drive_en_n  = 1'b0;
      default:    alu_drive_en_n  = 1'b1;
    endcase
  end

  // Hold stays on for the trick code so the parity check leaves no trace in the ALU
  assign alu_hold            = (dsp != `DSP_ALU);
  assign mult_instr_load_n   = 1'b0;
  assign mult_instr_passthru = 1'b1;
  assign mult_prod_passthru  = (dsp == `DSP_MULT);
  assign fpu_result_passthru = !f_clocked;
  assign fpu_flag_passthru   = !f_clocked;

  ////////////////////////////////////////////////////////////////////////////
  // External float status register

  logic                  fpu_cycle;
  logic                  load_now;
  logic                  pend_r;
  fsd_pkg::flags_t       flags_r;

  assign fpu_cycle = run && exec && float_path(dsp);
  assign load_now  = (fpu_cycle && !f_clocked) || (run && pend_r);

  // Clocked mode: the unit's own register holds the flags only after the cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
    end else if (run) begin
      pend_r <= fpu_cycle && f_clocked;
    end
  end

  // A new load wins over a software clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= '0;
    end else if (load_now) begin
      flags_r <= fpu_flags;
    end else if (stat_clr) begin
      flags_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Branch groups and error interrupt

  assign grp1 = {flags_r[`FLG_INEXACT] | flags_r[`FLG_NAN] | flags_r[`FLG_ZERO],
                 flags_r[`FLG_INVALID], flags_r[`FLG_UNDERFLOW],
                 flags_r[`FLG_OVERFLOW]};
  assign grp2 = {1'b0, flags_r[`FLG_ZERO], flags_r[`FLG_NAN],
                 flags_r[`FLG_INEXACT]};
  assign mw_target1  = mw_dest(branch_addr, grp1);
  assign mw_target2  = mw_dest(branch_addr, grp2);
  assign fpu_err_irq = flags_r[`FLG_OVERFLOW] | flags_r[`FLG_UNDERFLOW]
                     | flags_r[`FLG_INVALID];

  ////////////////////////////////////////////////////////////////////////////
  // Seed table

  logic [31:0]              seed_r;
  logic                     seed_wr;
  logic [`SEED_IDX_W-1:0]   seed_idx_r;

  seed_table u_seed (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .run      (run),
    .wr_en    (seed_wr),
    .wr_idx   (seed_idx_r),
    .wr_data  (hwdata),
    .a_bus_in (a_bus_in),
    .seed_r   (seed_r)
  );

  assign a_bus_out  = seed_r;
  assign a_bus_oe_n = !(seed_sel && seed_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave

  logic                     dp_wr_r;
  logic                     dp_rd_r;
  logic [11:0]              dp_ofs_r;
  logic                     addr_ok;

  // Always ready: no wait states and every answer is OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r  <= 1'b0;
      dp_rd_r  <= 1'b0;
      dp_ofs_r <= 12'h000;
    end else if (hready) begin
      dp_wr_r  <= addr_ok && hwrite;
      dp_rd_r  <= addr_ok && !hwrite;
      dp_ofs_r <= haddr[11:0];
    end
  end

  assign stat_clr = dp_wr_r && (dp_ofs_r == `OFS_CTRL) && hwdata[`CTRL_STAT_CLR];
  assign seed_wr  = dp_wr_r && (dp_ofs_r == `OFS_SEED_DATA);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seed_en_r <= 1'b1;
    end else if (dp_wr_r && dp_ofs_r == `OFS_CTRL) begin
      seed_en_r <= hwdata[`CTRL_SEED_EN];
    end
  end

  // Index steps after each data write so the table loads as a stream
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seed_idx_r <= '0;
    end else if (dp_wr_r && dp_ofs_r == `OFS_SEED_ADDR) begin
      seed_idx_r <= hwdata[`SEED_IDX_W-1:0];
    end else if (seed_wr) begin
      seed_idx_r <= seed_idx_r + 1'b1;
    end
  end

  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_rd_r) begin
      case (dp_ofs_r)
        `OFS_CTRL:      hrdata[`CTRL_SEED_EN] = seed_en_r;
        `OFS_STATUS: begin
          hrdata[`STAT_FLAGS_LSB +: `FLG_W]  = flags_r;
          hrdata[`STAT_GRP1_LSB +: `BR_GRP_W] = grp1;
          hrdata[`STAT_GRP2_LSB +: `BR_GRP_W] = grp2;
          hrdata[`STAT_IRQ]                  = fpu_err_irq;
          hrdata[`STAT_PEND]                 = pend_r;
        end
        `OFS_SEED_ADDR: hrdata[`SEED_IDX_W-1:0] = seed_idx_r;
        default:        hrdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_trick_enables: assert property ((dsp == `DSP_TRICK) |->
      (fpu_drive_en_n && !alu_drive_en_n && mult_drive_en_n))
    else $error("trick code enables wrong");
  a_trick_hold: assert property ((dsp == `DSP_TRICK) |-> alu_hold)
    else $error("ALU hold dropped in trick code");
  a_flag_mode: assert property (fpu_flag_passthru == fpu_result_passthru)
    else $error("flag register mode differs from result register");
  a_status_hold: assert property ((!load_now && !stat_clr) |=>
      $stable(flags_r))
    else $error("status changed with no float cycle");
  a_transp_load: assert property ((run && exec && float_path(dsp) && !f_clocked) |=>
      (flags_r == $past(fpu_flags)))
    else $error("transparent load missed");
  a_clocked_load: assert property ((run && exec && float_path(dsp) && f_clocked)
      ##1 run |=> (flags_r == $past(fpu_flags)))
    else $error("clocked load missed");
  a_grp1_or: assert property (grp1[3] == (|flags_r[5:3]))
    else $error("group one OR bit wrong");
  a_grp2_low: assert property ((grp2[3] == 1'b0) && (grp2[2:0] == flags_r[5:3]))
    else $error("group two wrong");
  a_mw_upper: assert property ((mw_target1[11:4] == branch_addr[11:4])
      && (mw_target2[3:0] == grp2))
    else $error("branch destination wrong");
  a_irq_flags: assert property (fpu_err_irq == (|flags_r[2:0]))
    else $error("error interrupt wrong");
  a_fpu_oe: assert property (!fpu_drive_en_n |-> (dsp == `DSP_FPU))
    else $error("float output enabled off path");
  a_seed_pipe: assert property ((run && seed_en_r && seed_sel) ##1 (seed_en_r && seed_sel) |->
      (a_bus_out == seed_r) && !a_bus_oe_n)
    else $error("seed not driven");
  a_mult_oe: assert property ((!mult_drive_en_n) == (dsp == `DSP_MULT))
    else $error("multiplier enable wrong");
  a_mult_instr: assert property (!mult_instr_load_n && mult_instr_passthru)
    else $error("multiplier instruction register not flowing");
  a_prod_ft: assert property (mult_prod_passthru |-> (dsp == `DSP_MULT))
    else $error("product flow-through off path");
  a_halt_freeze: assert property ((!run && !stat_clr) |=> $stable(flags_r) && $stable(seed_r))
    else $error("state changed while halted");
  a_alu_hold: assert property ((dsp != `DSP_ALU) |-> alu_hold)
    else $error("ALU not held off path");
  a_reset_clear: assert property ($rose(hresetn) |-> (flags_r == '0) && !fpu_err_irq)
    else $error("status not cleared by reset");
  // Pipeline depth of the status path, checked in both result register modes
  a_pend_set: assert property ((run && exec && float_path(dsp) && f_clocked) |=>
      pend_r)
    else $error("clocked float cycle left no pending load");
  a_pend_load: assert property ((run && pend_r) |=>
      (flags_r == $past(fpu_flags)))
    else $error("pending load missed");
  a_pend_clear: assert property ((run && !(exec && float_path(dsp) && f_clocked)) |=>
      !pend_r)
    else $error("pending load without clocked float cycle");
  a_pend_halt: assert property (!run |=>
      $stable(pend_r))
    else $error("pending load changed while halted");
  a_off_path: assert property ((run && exec && !float_path(dsp) && !pend_r && !stat_clr) |=>
      $stable(flags_r))
    else $error("status loaded from a non-float cycle");
  a_trick_load: assert property ((run && exec && (dsp == `DSP_TRICK) && !f_clocked) |=>
      (flags_r == $past(fpu_flags)))
    else $error("trick cycle did not load status");
  a_flag_thru: assert property (fpu_flag_passthru ==
      !f_clocked)
    else $error("flag register mode wrong");
  a_grp1_direct: assert property (grp1[2:0] ==
      flags_r[2:0])
    else $error("group one direct bits wrong");
  a_grp2_found: assert property ((|flags_r[5:3]) |->
      (grp1[3] && (grp2 != 4'h0)))
    else $error("second group misses the combined flag");
  a_mw_lower: assert property ((mw_target1[3:0] == grp1) &&
      (mw_target2[11:4] == branch_addr[11:4]))
    else $error("branch destination low bits wrong");
  a_no_flag: assert property ((flags_r == '0) |->
      ((mw_target1[3:0] == 4'h0) && (grp2 == 4'h0) && !fpu_err_irq))
    else $error("quiet status does not give zero offset");
  a_irq_each: assert property ((|flags_r[2:0]) |->
      fpu_err_irq)
    else $error("error flag raised no interrupt");
  a_fpu_path_oe: assert property ((dsp == `DSP_FPU) |->
      (!fpu_drive_en_n && alu_drive_en_n && mult_drive_en_n))
    else $error("float path enables wrong");
  a_alu_path: assert property ((dsp == `DSP_ALU) |->
      (!alu_drive_en_n && fpu_drive_en_n && mult_drive_en_n && !alu_hold))
    else $error("ALU path enables wrong");
  a_prod_mult: assert property ((dsp == `DSP_MULT) |->
      (mult_prod_passthru && alu_hold && fpu_drive_en_n))
    else $error("multiplier path controls wrong");
  a_seed_off: assert property ((!seed_sel || !seed_en_r) |->
      a_bus_oe_n)
    else $error("seed driven without request");

  c_trick: cover property (dsp == `DSP_TRICK && run && exec);
  c_clocked_load: cover property ((fpu_cycle && f_clocked) ##1 load_now);
  c_irq: cover property ($rose(fpu_err_irq));
  c_seed_drive: cover property (!a_bus_oe_n && seed_r != 32'h0000_0000);
  c_second_level: cover property (grp1[3] && grp2[2]);

endmodule

// file: hdl/fsd_defines.svh
// Offsets, field positions, codes and reset values for the float status and path decode block
`ifndef FSD_DEFINES_SVH
`define FSD_DEFINES_SVH

// Data path select codes
`define DSP_ALU          2'h0
`define DSP_FPU          2'h1
`define DSP_MULT         2'h2
`define DSP_TRICK        2'h3

// Float flag positions
`define FLG_OVERFLOW     0
`define FLG_UNDERFLOW    1
`define FLG_INVALID      2
`define FLG_INEXACT      3
`define FLG_NAN          4
`define FLG_ZERO         5
`define FLG_W            6

// Branch address
`define BR_ADDR_W        12
`define BR_GRP_W         4

// Seed table geometry
`define SEED_IDX_W       8
`define SEED_DEPTH       256
`define SEED_IDX_LSB     15
`define SEED_EXP_W       9
`define SEED_FHI_W       12
`define SEED_FLO_W       11

// Register byte offsets
`define OFS_CTRL         12'h000
`define OFS_STATUS       12'h004
`define OFS_SEED_ADDR    12'h008
`define OFS_SEED_DATA    12'h00c

// Control register fields
`define CTRL_SEED_EN     0
`define CTRL_STAT_CLR    1
`define CTRL_RST         32'h0000_0001

// Status register fields
`define STAT_FLAGS_LSB   0
`define STAT_GRP1_LSB    8
`define STAT_GRP2_LSB    12
`define STAT_IRQ         16
`define STAT_PEND        17

// Bus codes
`define HTRANS_NONSEQ    2'h2
`define HTRANS_SEQ       2'h3
`define HSIZE_WORD       3'h2

`endif

// file: hdl/fsd_pkg.sv
// Types shared by the float status and path decode block
package fsd_pkg;
  typedef logic [5:0]  flags_t;
  typedef logic [1:0]  dsp_t;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {SEL_NONE, SEL_FPU, SEL_SEED_DATA} wr_kind_e;
endpackage

// file: hdl/seed_table.sv
// Division seed lookup table with registered output onto the operand A bus
`timescale 1ns/100ps
`include "fsd_defines.svh"
module seed_table (
  // Clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    run,
  // Table loading
  input  wire logic                    wr_en,
  input  wire logic [`SEED_IDX_W-1:0]  wr_idx,
  input  wire logic [31:0]             wr_data,
  // Operand bus
  input  wire logic [31:0]             a_bus_in,
  output      logic [31:0]             seed_r
);
  // One element per field, each addressed by the same operand bits
  logic [`SEED_EXP_W-1:0] exp_mem [`SEED_DEPTH];
  logic [`SEED_FHI_W-1:0] fhi_mem [`SEED_DEPTH];
  logic [`SEED_FLO_W-1:0] flo_mem [`SEED_DEPTH];
  logic [`SEED_IDX_W-1:0] idx;

  assign idx = a_bus_in[`SEED_IDX_LSB +: `SEED_IDX_W];

  // No reset on the array: contents come from software
  always_ff @(posedge hclk) begin
    if (wr_en) begin
      exp_mem[wr_idx] <= wr_data[31 -: `SEED_EXP_W];
      fhi_mem[wr_idx] <= wr_data[`SEED_FLO_W +: `SEED_FHI_W];
      flo_mem[wr_idx] <= wr_data[`SEED_FLO_W-1:0];
    end
  end

  // Seed registered on the data clock, driven back next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seed_r <= 32'h0000_0000;
    end else if (run) begin
      seed_r <= {exp_mem[idx], fhi_mem[idx], flo_mem[idx]};
    end
  end
endmodule

// file: tb/ctrl_pipe_model.sv
// Behavioural control pipeline register and microsequencer on the far side of the block
`timescale 1ns/100ps
module ctrl_pipe_model (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // Microword fields from the bench
  input  wire logic                  uw_run,
  input  wire logic                  uw_exec,
  input  wire fsd_pkg::dsp_t         uw_dsp,
  input  wire logic                  uw_fclk,
  input  wire logic                  uw_seed,
  input  wire logic [11:0]           uw_baddr,
  // Multi-way branch request
  input  wire logic                  mw_take,
  input  wire logic                  mw_second,
  input  wire logic [11:0]           mw_target1,
  input  wire logic [11:0]           mw_target2,
  // Pipeline fields to the block
  output      logic                  run,
  output      logic                  exec,
  output      fsd_pkg::dsp_t         dsp,
  output      logic                  f_clocked,
  output      logic                  seed_sel,
  output      logic [11:0]           branch_addr,
  // Sequencer state
  output      logic [11:0]           upc_r
);
  ////////////////////////////////////////////////////////////////////////////////
  // Fields change only just after an edge, because the bench updates the microword there
  assign run         = uw_run;
  assign exec        = uw_exec;
  assign dsp         = uw_dsp;  // Trick cycles are never paired with a result-bus load here
  assign f_clocked   = uw_fclk;
  assign seed_sel    = uw_seed;
  assign branch_addr = uw_baddr;
  ////////////////////////////////////////////////////////////////////////////////
  // Step holds between branches so the bench can read the landing address at leisure
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upc_r <= 12'h000;
    end else if (mw_take) begin
      upc_r <= mw_second ? mw_target2 : mw_target1;
    end
  end
endmodule

// file: tb/tb.sv
// Self-checking bench for the float status and path decode block
`timescale 1ns/100ps
`include "fsd_defines.svh"
module tb;
  logic                  hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]           haddr, hwdata, hrdata, a_bus_in, a_bus_out;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic                  uw_run, uw_exec, uw_fclk, uw_seed, mw_take, mw_second;
  logic                  run, exec, f_clocked, seed_sel, a_bus_oe_n, fpu_err_irq;
  logic                  fpu_flag_passthru, fpu_result_passthru, fpu_drive_en_n, alu_drive_en_n, alu_hold;
  logic                  mult_drive_en_n, mult_instr_load_n, mult_instr_passthru, mult_prod_passthru;
  fsd_pkg::dsp_t         uw_dsp, dsp;
  logic [11:0]           uw_baddr, branch_addr, mw_target1, mw_target2, upc_r;
  logic [3:0]            grp1, grp2;
  fsd_pkg::flags_t       fpu_flags, st;
  fsd_pkg::word_t        rd;
  int                    n_errors, samples_checked, cyc;

  float_status_and_path_decode float_status_and_path_decode_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .run(run), .exec(exec), .dsp(dsp), .f_clocked(f_clocked), .seed_sel(seed_sel), .branch_addr(branch_addr),
    .fpu_flags(fpu_flags), .fpu_flag_passthru(fpu_flag_passthru), .fpu_result_passthru(fpu_result_passthru),
    .fpu_drive_en_n(fpu_drive_en_n), .alu_drive_en_n(alu_drive_en_n), .alu_hold(alu_hold),
    .mult_drive_en_n(mult_drive_en_n), .mult_instr_load_n(mult_instr_load_n),
    .mult_instr_passthru(mult_instr_passthru), .mult_prod_passthru(mult_prod_passthru),
    .mw_target1(mw_target1), .mw_target2(mw_target2), .grp1(grp1), .grp2(grp2), .fpu_err_irq(fpu_err_irq),
    .a_bus_in(a_bus_in), .a_bus_out(a_bus_out), .a_bus_oe_n(a_bus_oe_n)
  );

  ctrl_pipe_model ctrl_pipe_model_inst (
    .hclk(hclk), .hresetn(hresetn), .uw_run(uw_run), .uw_exec(uw_exec), .uw_dsp(uw_dsp), .uw_fclk(uw_fclk),
    .uw_seed(uw_seed), .uw_baddr(uw_baddr), .mw_take(mw_take), .mw_second(mw_second),
    .mw_target1(mw_target1), .mw_target2(mw_target2), .run(run), .exec(exec), .dsp(dsp),
    .f_clocked(f_clocked), .seed_sel(seed_sel), .branch_addr(branch_addr), .upc_r(upc_r)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Ceiling is over twenty times the expected run length of about 130 cycles, so only a hang reaches it
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input fsd_pkg::word_t exp, input fsd_pkg::word_t got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task print_verdict;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One single word transfer; request held until hready is seen high at an edge
  task ahb(input logic wr, input fsd_pkg::word_t a, input fsd_pkg::word_t wd, output fsd_pkg::word_t rdv);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= `HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask

  // One microword cycle, then an idle cycle with flipped flags to catch late sampling
  task fcyc(input fsd_pkg::flags_t f, input fsd_pkg::dsp_t d, input logic ex, input logic rn);
    @(posedge hclk);
    fpu_flags <= f;
    uw_dsp <= d;
    uw_exec <= ex;
    uw_run <= rn;
    @(posedge hclk);
    fpu_flags <= ~f;
    uw_dsp <= `DSP_ALU;
    uw_exec <= 1'b0;
    uw_run <= 1'b1;
  endtask

  task chk_st;
    logic [3:0] e1;
    logic [3:0] e2;
    e1 = {|st[5:3], st[2:0]};
    e2 = {1'b0, st[5:3]};
    #1;
    chk("grp1", e1, grp1);
    chk("grp2", e2, grp2);
    chk("irq", |st[2:0], fpu_err_irq);
    chk("target1", {uw_baddr[11:4], e1}, mw_target1);
    chk("target2", {uw_baddr[11:4], e2}, mw_target2);
    @(posedge hclk);
    mw_take <= 1'b1;
    mw_second <= e1[3];
    @(posedge hclk);
    mw_take <= 1'b0;
    ahb(1'b0, `OFS_STATUS, 32'h0, rd);
    chk("status", {14'h0, 1'b0, |st[2:0], e2, e1, 2'h0, st}, rd);
    #1;
    chk("upc", {uw_baddr[11:4], e1[3] ? e2 : e1}, upc_r);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite, uw_exec, uw_fclk, uw_seed, mw_take, mw_second} = 8'h00;
    {haddr, hwdata, a_bus_in} = 96'h0;
    htrans = 2'h0;
    hsize = `HSIZE_WORD;
    uw_run = 1'b1;
    uw_dsp = `DSP_ALU;
    uw_baddr = 12'ha5c;
    fpu_flags = 6'h00;
    st = 6'h00;
    n_errors = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    chk_st;
    // Entry 0 loaded so the seed register holds no unknown while the bus idles at zero
    ahb(1'b1, `OFS_SEED_DATA, 32'h0, rd);
    ahb(1'b0, `OFS_CTRL, 32'h0, rd);
    chk("ctrl", `CTRL_RST, rd);
    ahb(1'b0, 32'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 8; i++) begin
      @(posedge hclk);
      uw_dsp <= i[1:0];
      uw_fclk <= i[2];
      #1;
      chk("fpu_oe_n", i[1:0] != `DSP_FPU, fpu_drive_en_n);
      chk("alu_oe_n", i[1:0] == `DSP_FPU || i[1:0] == `DSP_MULT, alu_drive_en_n);
      chk("alu_hold", i[1:0] != `DSP_ALU, alu_hold);
      chk("mult_oe_n", i[1:0] != `DSP_MULT, mult_drive_en_n);
      chk("prod_thru", i[1:0] == `DSP_MULT, mult_prod_passthru);
      chk("instr_ld_n", 32'h0, mult_instr_load_n);
      chk("instr_thru", 32'h1, mult_instr_passthru);
      chk("flag_thru", !i[2], fpu_flag_passthru);
      chk("result_thru", !i[2], fpu_result_passthru);
    end
    @(posedge hclk);
    uw_fclk <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      fcyc(6'h01 << i, i[0] ? `DSP_TRICK : `DSP_FPU, 1'b1, 1'b1);
      st = 6'h01 << i;
      chk_st;
    end
    fcyc(6'h3f, `DSP_ALU, 1'b1, 1'b1);
    fcyc(6'h3f, `DSP_MULT, 1'b1, 1'b1);
    fcyc(6'h3f, `DSP_FPU, 1'b0, 1'b1);
    fcyc(6'h3f, `DSP_FPU, 1'b1, 1'b0);
    chk_st;
    fcyc(6'h3f, `DSP_FPU, 1'b1, 1'b1);
    st = 6'h3f;
    chk_st;
    ahb(1'b1, `OFS_CTRL, 32'h3, rd);
    st = 6'h00;
    chk_st;
    ahb(1'b0, `OFS_CTRL, 32'h0, rd);
    chk("ctrl_clr", 32'h1, rd);
    // Clocked mode: flags of the following cycle land one edge later
    @(posedge hclk);
    uw_fclk <= 1'b1;
    uw_dsp <= `DSP_FPU;
    uw_exec <= 1'b1;
    fpu_flags <= 6'h01;
    @(posedge hclk);
    uw_dsp <= `DSP_ALU;
    uw_exec <= 1'b0;
    fpu_flags <= 6'h22;
    #1;
    chk("grp1_early", 32'h0, grp1);
    @(posedge hclk);
    fpu_flags <= 6'h00;
    st = 6'h22;
    chk_st;
    ahb(1'b1, `OFS_SEED_ADDR, 32'h5, rd);
    ahb(1'b1, `OFS_SEED_DATA, 32'h1234_5678, rd);
    ahb(1'b1, `OFS_SEED_DATA, 32'h8765_4321, rd);
    ahb(1'b0, `OFS_SEED_ADDR, 32'h0, rd);
    chk("seed_idx", 32'h7, rd);
    @(posedge hclk);
    a_bus_in <= 32'h5 << `SEED_IDX_LSB;
    uw_seed <= 1'b1;
    uw_fclk <= 1'b0;
    @(posedge hclk);
    a_bus_in <= 32'h6 << `SEED_IDX_LSB;
    #1;
    chk("seed", 32'h1234_5678, a_bus_out);
    chk("seed_oe_n", 32'h0, a_bus_oe_n);
    @(posedge hclk);
    uw_run <= 1'b0;
    a_bus_in <= 32'h5 << `SEED_IDX_LSB;
    #1;
    chk("seed_next", 32'h8765_4321, a_bus_out);
    @(posedge hclk);
    uw_run <= 1'b1;
    uw_seed <= 1'b0;
    #1;
    chk("seed_held", 32'h8765_4321, a_bus_out);
    chk("seed_oe_off", 32'h1, a_bus_oe_n);
    @(posedge hclk);
    #1;
    chk("seed_back", 32'h1234_5678, a_bus_out);
    ahb(1'b1, `OFS_CTRL, 32'h0, rd);
    @(posedge hclk);
    uw_seed <= 1'b1;
    #1;
    chk("seed_dis", 32'h1, a_bus_oe_n);
    print_verdict;
  end
endmodule
